// ==== deewc_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module deewc_ctrl
	import deewc_pkg::*;
#(
	parameter int T_ER0 = DEEWC_T_ER0_CYC, // Erase cycles, fast select
	parameter int T_ER1 = DEEWC_T_ER1_CYC, // Erase cycles, slow select
	parameter int T_WR0 = DEEWC_T_WR0_CYC, // Write cycles, fast select
	parameter int T_WR1 = DEEWC_T_WR1_CYC // Write cycles, slow select
) (
	input wire logic ref_clk, // System clock
	input wire logic nrst, // Async reset, active low
	input wire logic mode_page, // 1 page mode, 0 byte mode
	input wire logic time_sel, // Erase/write time select
	input wire logic erase_enable_set, // Pulse: set erase enable
	input wire logic erase_enable_clr, // Pulse: clear erase enable
	input wire logic erase_start_set, // Pulse: set erase start
	input wire logic write_enable_set, // Pulse: set write enable
	input wire logic write_enable_clr, // Pulse: clear write enable
	input wire logic write_start_set, // Pulse: set write start
	input wire logic addr_wr, // Pulse: load address
	input wire logic [9:0] addr_in, // Address to load
	input wire logic data_wr, // Pulse: data register write
	input wire logic [7:0] data_in, // Data register value
	input wire logic irq_ack, // Pulse: interrupt serviced
	input wire logic timer_done, // Async internal timer done level
	output logic erase_enable, // Erase enable bit
	output logic erase_start, // Erase start bit, busy
	output logic write_enable_bit, // Write enable bit
	output logic write_start, // Write start bit, busy
	output logic [9:0] eeprom_addr, // Current address
	output logic eeprom_irq_flag, // Interrupt request flag
	output logic timer_run, // Request to internal timer
	output logic mem_we, // Array byte program strobe
	output logic [9:0] mem_addr, // Array byte address
	output logic [7:0] mem_wdata // Array byte data
);
	////////////////////////////////////////////////////////////////////////
	deewc_state_t state_ff; // Operation state
	logic er_en_ff, er_st_ff, wr_en_ff, wr_st_ff; // Control bits
	logic er_en_d1_ff, wr_en_d1_ff; // Last-cycle enable-set markers
	logic [9:0] addr_ff; // Page and offset
	logic [7:0] data_ff; // Data register
	logic [7:0] buf_ff [DEEWC_PAGE_BYTES]; // Page buffer data
	logic [15:0] tag_ff; // Byte tagged by a data write
	logic sat_ff; // Offset held at last, writes ignored
	logic tmr_s1_ff, tmr_s2_ff, tmr_s3_ff; // Timer done sync
	logic [DEEWC_CNT_W-1:0] cnt_ff; // Self timer for the cycle
	logic [4:0] idx_ff; // Byte index during commit
	logic irq_ff; // Interrupt flag
	logic done_evt; // Synced cycle end
	logic start_er, start_wr; // Accepted activations
	logic buf_clr; // Enable fell
	logic [DEEWC_CNT_W-1:0] cyc_len; // Selected cycle length
	logic [DEEWC_OFS_W-1:0] ofs;
	assign ofs = addr_ff[DEEWC_OFS_W-1:0];
	////////////////////////////////////////////////////////////////////////
	// Cycle length from time select
	always_comb begin
		if (er_st_ff)
			cyc_len = time_sel ? DEEWC_CNT_W'(T_ER1) : DEEWC_CNT_W'(T_ER0);
		else
			cyc_len = time_sel ? DEEWC_CNT_W'(T_WR1) : DEEWC_CNT_W'(T_WR0);
	end
	// Start only when enable was set in the previous instruction
	assign start_er = erase_start_set && er_en_d1_ff && er_en_ff && mode_page && (state_ff == DEEWC_IDLE);
	assign start_wr = write_start_set && wr_en_d1_ff && wr_en_ff && (state_ff == DEEWC_IDLE);
	// Buffer cleared only on a 1-to-0 enable change
	logic nxt_er_en, nxt_wr_en; // Next enable values
	assign buf_clr = (er_en_ff && !nxt_er_en) || (wr_en_ff && !nxt_wr_en);
	always_comb begin
		nxt_er_en = er_en_ff;
		nxt_wr_en = wr_en_ff;
		if (erase_enable_set)
			nxt_er_en = 1'b1;
		if (erase_enable_clr)
			nxt_er_en = 1'b0;
		if (write_enable_set)
			nxt_wr_en = 1'b1;
		if (write_enable_clr)
			nxt_wr_en = 1'b0;
		// Hardware clears enables when the cycle ends
		if (done_evt && er_st_ff)
			nxt_er_en = 1'b0;
		if (done_evt && wr_st_ff)
			nxt_wr_en = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// Timer done crosses in; the second and third stages feed the edge logic
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			tmr_s1_ff <= 1'b0;
			tmr_s2_ff <= 1'b0;
			tmr_s3_ff <= 1'b0;
		end else begin
			tmr_s1_ff <= timer_done;
			tmr_s2_ff <= tmr_s1_ff;
			tmr_s3_ff <= tmr_s2_ff;
		end
	end
	// Cycle ends on the async timer or the local bound, whichever first
	assign done_evt = (state_ff == DEEWC_DONE);
	////////////////////////////////////////////////////////////////////////
	// Enable bits, zero from power-on
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			er_en_ff <= 1'b0;
			wr_en_ff <= 1'b0;
			er_en_d1_ff <= 1'b0;
			wr_en_d1_ff <= 1'b0;
		end else begin
			er_en_ff <= nxt_er_en;
			wr_en_ff <= nxt_wr_en;
			er_en_d1_ff <= erase_enable_set;
			wr_en_d1_ff <= write_enable_set;
		end
	end
	// Start bits: set on accepted activation, cleared at cycle end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			er_st_ff <= 1'b0;
			wr_st_ff <= 1'b0;
		end else begin
			if (start_er)
				er_st_ff <= 1'b1;
			else if (done_evt)
				er_st_ff <= 1'b0;
			if (start_wr)
				wr_st_ff <= 1'b1;
			else if (done_evt)
				wr_st_ff <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Operation sequencer; commit phase walks the 16 buffer bytes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= DEEWC_IDLE;
			cnt_ff <= '0;
			idx_ff <= '0;
		end else begin
			case (state_ff)
				DEEWC_IDLE: begin
					cnt_ff <= '0;
					idx_ff <= '0;
					if (start_er)
						state_ff <= DEEWC_ERASE;
					else if (start_wr)
						state_ff <= DEEWC_WRITE;
				end
				DEEWC_ERASE, DEEWC_WRITE: begin
					if (idx_ff < 5'(DEEWC_PAGE_BYTES))
						idx_ff <= idx_ff + 5'h01;
					cnt_ff <= cnt_ff + {{(DEEWC_CNT_W-1){1'b0}}, 1'b1};
					if ((tmr_s2_ff && !tmr_s3_ff) || (cnt_ff >= cyc_len - 1'b1))
						state_ff <= DEEWC_DONE;
				end
				DEEWC_DONE:
					state_ff <= DEEWC_IDLE;
				default:
					state_ff <= DEEWC_IDLE;
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Array strobes: erase writes zero to tagged bytes; byte write
	// erases then programs; page write programs tagged buffer bytes
	logic [3:0] i4;
	assign i4 = idx_ff[3:0];
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mem_we <= 1'b0;
			mem_addr <= DEEWC_ADDR_RST;
			mem_wdata <= DEEWC_DATA_RST;
		end else begin
			mem_we <= 1'b0;
			if (state_ff == DEEWC_ERASE && !idx_ff[4] && tag_ff[i4]) begin
				mem_we <= 1'b1;
				mem_addr <= {addr_ff[9:4], i4};
				mem_wdata <= DEEWC_ERASED;
			end else if (state_ff == DEEWC_WRITE && !mode_page && idx_ff < 5'h02) begin
				mem_we <= 1'b1;
				mem_addr <= addr_ff;
				mem_wdata <= (idx_ff == 5'h00) ? DEEWC_ERASED : data_ff;
			end else if (state_ff == DEEWC_WRITE && mode_page && !idx_ff[4] && tag_ff[i4]) begin
				mem_we <= 1'b1;
				mem_addr <= {addr_ff[9:4], i4};
				mem_wdata <= buf_ff[i4];
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Address, data and saturating offset
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			addr_ff <= DEEWC_ADDR_RST;
			data_ff <= DEEWC_DATA_RST;
			sat_ff <= 1'b0;
		end else if (addr_wr) begin
			addr_ff <= addr_in;
			sat_ff <= 1'b0;
		end else if (data_wr && !sat_ff && state_ff == DEEWC_IDLE) begin
			data_ff <= data_in;
			if (mode_page) begin
				// Only the offset moves; it parks at the last byte
				if (ofs == DEEWC_OFS_LAST)
					sat_ff <= 1'b1;
				else
					addr_ff[3:0] <= ofs + DEEWC_OFS_ONE;
			end
		end
	end
	// Page buffer and tags, one entry per byte
	genvar g;
	generate
		for (g = 0; g < DEEWC_PAGE_BYTES; g++) begin : g_buf
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					buf_ff[g] <= DEEWC_DATA_RST;
					tag_ff[g] <= 1'b0;
				end else if (buf_clr) begin
					buf_ff[g] <= DEEWC_DATA_RST;
					tag_ff[g] <= 1'b0;
				end else if (data_wr && mode_page && !sat_ff && !addr_wr &&
						state_ff == DEEWC_IDLE && ofs == 4'(g)) begin
					buf_ff[g] <= data_in;
					tag_ff[g] <= 1'b1;
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////
	// Interrupt flag; a new cycle end beats a same-cycle service
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			irq_ff <= 1'b0;
		else if (done_evt)
			irq_ff <= 1'b1;
		else if (irq_ack)
			irq_ff <= 1'b0;
	end
	assign erase_enable = er_en_ff;
	assign erase_start = er_st_ff;
	assign write_enable_bit = wr_en_ff;
	assign write_start = wr_st_ff;
	assign eeprom_addr = addr_ff;
	assign eeprom_irq_flag = irq_ff;
	assign timer_run = state_ff == DEEWC_ERASE || state_ff == DEEWC_WRITE;
	////////////////////////////////////////////////////////////////////////
	property p_er_start_needs_enable;
		@(posedge ref_clk) disable iff (!nrst)
		$rose(er_st_ff) |-> $past(er_en_d1_ff) && $past(mode_page);
	endproperty
	a_er_start_needs_enable: assert property (p_er_start_needs_enable) else $error("erase start without enable");
	property p_wr_start_needs_enable;
		@(posedge ref_clk) disable iff (!nrst)
		$rose(wr_st_ff) |-> $past(wr_en_d1_ff) && $past(wr_en_ff);
	endproperty
	a_wr_start_needs_enable: assert property (p_wr_start_needs_enable) else $error("write start without enable");
	sequence s_end;
		state_ff == DEEWC_DONE;
	endsequence
	property p_end_clears;
		@(posedge ref_clk) disable iff (!nrst)
		s_end |=> !er_st_ff && !wr_st_ff && irq_ff;
	endproperty
	a_end_clears: assert property (p_end_clears) else $error("cycle end did not clear");
	property p_er_en_cleared;
		@(posedge ref_clk) disable iff (!nrst)
		(s_end and er_st_ff) |=> !er_en_ff;
	endproperty
	a_er_en_cleared: assert property (p_er_en_cleared) else $error("erase enable not cleared");
	property p_wr_en_cleared;
		@(posedge ref_clk) disable iff (!nrst)
		(s_end and wr_st_ff) |=> !wr_en_ff;
	endproperty
	a_wr_en_cleared: assert property (p_wr_en_cleared) else $error("write enable not cleared");
	property p_page_fixed;
		@(posedge ref_clk) disable iff (!nrst)
		(data_wr && !addr_wr) |=> addr_ff[9:4] == $past(addr_ff[9:4]);
	endproperty
	a_page_fixed: assert property (p_page_fixed) else $error("page bits moved");
	property p_sat_hold;
		@(posedge ref_clk) disable iff (!nrst)
		(sat_ff && !addr_wr) |=> ofs == DEEWC_OFS_LAST && data_ff == $past(data_ff);
	endproperty
	a_sat_hold: assert property (p_sat_hold) else $error("saturated offset moved");
	property p_erase_zero;
		@(posedge ref_clk) disable iff (!nrst)
		(state_ff == DEEWC_ERASE && !idx_ff[4] && tag_ff[i4]) |=> mem_we && mem_wdata == DEEWC_ERASED;
	endproperty
	a_erase_zero: assert property (p_erase_zero) else $error("erase not zero");
	property p_buf_clear;
		@(posedge ref_clk) disable iff (!nrst)
		buf_clr |=> tag_ff == 16'h0000;
	endproperty
	a_buf_clear: assert property (p_buf_clear) else $error("buffer not cleared");
endmodule
`default_nettype wire

// ==== deewc_pkg.sv ====
`default_nettype none
package deewc_pkg;
	// Address split: 10-bit address, 6-bit page, 4-bit offset
	localparam int DEEWC_ADDR_W = 10;
	localparam int DEEWC_OFS_W = 4;
	localparam int DEEWC_PAGE_W = 6;
	localparam int DEEWC_PAGE_BYTES = 16;
	localparam logic [3:0] DEEWC_OFS_LAST = 4'hf;
	localparam logic [3:0] DEEWC_OFS_ONE = 4'h1;
	localparam logic [7:0] DEEWC_ERASED = 8'h00;
	localparam logic [7:0] DEEWC_DATA_RST = 8'h00;
	localparam logic [9:0] DEEWC_ADDR_RST = 10'h000;
	// Cycle times in microseconds, fast/slow select
	localparam int DEEWC_CLK_MHZ = 50;
	localparam int DEEWC_T_ER0_US = 3200;
	localparam int DEEWC_T_ER1_US = 3700;
	localparam int DEEWC_T_WR0_US = 2200;
	localparam int DEEWC_T_WR1_US = 3000;
	localparam int DEEWC_T_ER0_CYC = DEEWC_T_ER0_US * DEEWC_CLK_MHZ;
	localparam int DEEWC_T_ER1_CYC = DEEWC_T_ER1_US * DEEWC_CLK_MHZ;
	localparam int DEEWC_T_WR0_CYC = DEEWC_T_WR0_US * DEEWC_CLK_MHZ;
	localparam int DEEWC_T_WR1_CYC = DEEWC_T_WR1_US * DEEWC_CLK_MHZ;
	localparam int DEEWC_CNT_W = 18;
	// Operation state, one-hot
	typedef enum logic [3:0] {
		DEEWC_IDLE = 4'b0001,
		DEEWC_ERASE = 4'b0010,
		DEEWC_WRITE = 4'b0100,
		DEEWC_DONE = 4'b1000
	} deewc_state_t;
endpackage
`default_nettype wire

// ==== deewc_ctrl_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module deewc_ctrl_tb
	import deewc_pkg::*;
;
	// Short cycle counts keep the run brief; the timer edge still races them
	localparam int P_E0 = 40;
	localparam int P_E1 = 60;
	localparam int P_W0 = 30;
	localparam int P_W1 = 50;
	// One operation: kind, mode, timing, activation gap, bytes, expectations
	typedef struct packed {
		logic op; // 1 write, 0 erase
		logic pg; // Page mode
		logic ts; // Time select
		logic td; // Raise timer done early
		logic go; // Cycle should start
		logic [1:0] gap; // Idle cycles between enable and start
		logic [4:0] nb; // Data register writes
		logic [4:0] nwe; // Array strobes expected
		logic [9:0] a; // Loaded address
		logic [9:0] ea; // Address expected afterwards
	} deewc_row_t;
	deewc_row_t rows [10] = '{
		'{1, 0, 0, 0, 1, 0, 1, 2, 10'h123, 10'h123},
		'{1, 0, 1, 0, 1, 0, 1, 2, 10'h3fe, 10'h3fe},
		'{0, 1, 0, 0, 1, 0, 16, 16, 10'h2a0, 10'h2af},
		'{0, 0, 0, 0, 0, 0, 1, 0, 10'h040, 10'h040},
		'{0, 1, 1, 1, 1, 0, 2, 2, 10'h15e, 10'h15f},
		'{1, 1, 0, 0, 0, 1, 4, 0, 10'h0c0, 10'h0c4},
		'{1, 1, 0, 0, 1, 0, 0, 0, 10'h0c0, 10'h0c0},
		'{1, 1, 1, 0, 1, 0, 20, 8, 10'h2a8, 10'h2af},
		'{1, 1, 0, 1, 1, 0, 5, 5, 10'h3c4, 10'h3c9},
		'{0, 1, 0, 0, 0, 2, 1, 0, 10'h200, 10'h201}
	};
	logic ref_clk = 1'b0; // System clock
	logic nrst, mode_page, time_sel, irq_ack, timer_done; // Levels and pulses
	logic erase_enable_set, erase_enable_clr, erase_start_set; // Erase controls
	logic write_enable_set, write_enable_clr, write_start_set; // Write controls
	logic addr_wr, data_wr; // Register write pulses
	logic [9:0] addr_in; // Address value
	logic [7:0] data_in; // Data value
	logic erase_enable, erase_start, write_enable_bit, write_start, eeprom_irq_flag, timer_run, mem_we;
	logic [9:0] eeprom_addr, mem_addr; // Current and array addresses
	logic [7:0] mem_wdata; // Array data
	int bad_count = 0; // Mismatches
	int tests_run = 0; // Comparisons
	int we_cnt, wd_err, cyc; // Monitor counts
	logic cur_op; // Kind of the running operation
	logic [5:0] cur_pg; // Page of the running operation
	logic [7:0] f_d, l_d; // First and last array data
	logic [9:0] l_a; // Last array address

	deewc_ctrl #(.T_ER0(P_E0), .T_ER1(P_E1), .T_WR0(P_W0), .T_WR1(P_W1)) u_deewc_ctrl (
		.ref_clk(ref_clk), .nrst(nrst), .mode_page(mode_page), .time_sel(time_sel),
		.erase_enable_set(erase_enable_set), .erase_enable_clr(erase_enable_clr),
		.erase_start_set(erase_start_set), .write_enable_set(write_enable_set),
		.write_enable_clr(write_enable_clr), .write_start_set(write_start_set),
		.addr_wr(addr_wr), .addr_in(addr_in), .data_wr(data_wr), .data_in(data_in),
		.irq_ack(irq_ack), .timer_done(timer_done), .erase_enable(erase_enable),
		.erase_start(erase_start), .write_enable_bit(write_enable_bit), .write_start(write_start),
		.eeprom_addr(eeprom_addr), .eeprom_irq_flag(eeprom_irq_flag), .timer_run(timer_run),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock, and a cycle ceiling so a stuck busy bit cannot hang the run
	always #10 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 8000) begin
			bad_count++;
			$display("timeout after %0d cycles", cyc);
			print_verdict();
		end
	end

	// Array strobe monitor; byte writes see a zero pass first, so page checks only
	always @(posedge ref_clk) begin
		if (mem_we === 1'b1) begin
			if (we_cnt == 0) f_d = mem_wdata;
			l_d = mem_wdata;
			l_a = mem_addr;
			we_cnt++;
			if (mem_addr[9:4] !== cur_pg) wd_err++;
			if (mem_wdata !== (cur_op ? {4'h5, mem_addr[3:0]} : DEEWC_ERASED)) wd_err++;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare and count
	// Wide enough for the whole reset snapshot and the monitor counts
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Final report, the only way out of the run
	task print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Load address and data, activate, wait for the end, then acknowledge
	task automatic run(input deewc_row_t r);
		int n;
		int t;
		logic [3:0] o;
		cur_op = r.op;
		cur_pg = r.a[9:4];
		we_cnt = 0;
		wd_err = 0;
		t = r.op ? (r.ts ? P_W1 : P_W0) : (r.ts ? P_E1 : P_E0);
		o = r.a[3:0];
		@(posedge ref_clk);
		mode_page <= r.pg;
		time_sel <= r.ts;
		addr_wr <= 1'b1;
		addr_in <= r.a;
		// Back-to-back data writes; writes past the last offset carry a marker value
		for (int k = 0; k < r.nb; k++) begin
			@(posedge ref_clk);
			addr_wr <= 1'b0;
			data_wr <= 1'b1;
			data_in <= (r.pg && r.a[3:0] + k > 15) ? 8'hee : {4'h5, o};
			if (r.pg && o != DEEWC_OFS_LAST) o = o + 4'h1;
		end
		@(posedge ref_clk);
		addr_wr <= 1'b0;
		data_wr <= 1'b0;
		if (r.op) write_enable_set <= 1'b1;
		else erase_enable_set <= 1'b1;
		repeat (r.gap) begin
			@(posedge ref_clk);
			erase_enable_set <= 1'b0;
			write_enable_set <= 1'b0;
		end
		@(posedge ref_clk);
		erase_enable_set <= 1'b0;
		write_enable_set <= 1'b0;
		if (r.op) write_start_set <= 1'b1;
		else erase_start_set <= 1'b1;
		@(posedge ref_clk);
		erase_start_set <= 1'b0;
		write_start_set <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("start bit", r.op ? write_start : erase_start, r.go);
		chk("timer run", timer_run, r.go);
		n = 2;
		// Poll the start bit as software would, bounded
		while ((erase_start | write_start) === 1'b1 && n < 400) begin
			@(posedge ref_clk);
			n++;
			// Timer edge comes after the 16-byte commit walk, as a real timer would
			if (r.td && n == 20) timer_done <= 1'b1;
			#1;
		end
		if (r.go) begin
			chk("cycle length", r.td ? (n >= 22 && n <= 28) : (n >= t - 4 && n <= t + 8), 1);
			chk("enable cleared", r.op ? write_enable_bit : erase_enable, 0);
			chk("irq raised", eeprom_irq_flag, 1);
		end
		@(posedge ref_clk);
		timer_done <= 1'b0;
		irq_ack <= r.go;
		erase_enable_clr <= !r.go;
		write_enable_clr <= !r.go;
		@(posedge ref_clk);
		irq_ack <= 1'b0;
		erase_enable_clr <= 1'b0;
		write_enable_clr <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("irq after ack", eeprom_irq_flag, 0);
		chk("enables", {erase_enable, write_enable_bit}, 0);
		chk("timer idle", timer_run, 0);
		chk("strobe count", we_cnt, r.nwe);
		chk("address", eeprom_addr, r.ea);
		if (r.pg) chk("page data", wd_err, 0);
		else if (r.go) chk("byte data", {f_d, l_d}, {DEEWC_ERASED, 4'h5, r.a[3:0]});
		if (!r.pg && r.go) chk("byte addr", l_a, r.a);
		$display("test done: op %0d page %0d addr %h", r.op, r.pg, r.a);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence: table rows, then a reset in mid-run
	initial begin
		{nrst, mode_page, time_sel, irq_ack, timer_done, addr_wr, data_wr} = '0;
		{erase_enable_set, erase_enable_clr, erase_start_set} = '0;
		{write_enable_set, write_enable_clr, write_start_set} = '0;
		addr_in = '0;
		data_in = '0;
		cyc = 0;
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		foreach (rows[i]) run(rows[i]);
		// Tag a byte and raise an enable, then reset while they stand
		@(posedge ref_clk);
		mode_page <= 1'b1;
		addr_wr <= 1'b1;
		addr_in <= 10'h080;
		@(posedge ref_clk);
		addr_wr <= 1'b0;
		data_wr <= 1'b1;
		data_in <= 8'h55;
		@(posedge ref_clk);
		data_wr <= 1'b0;
		erase_enable_set <= 1'b1;
		@(posedge ref_clk);
		erase_enable_set <= 1'b0;
		nrst <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("reset outputs", {erase_enable, erase_start, write_enable_bit, write_start,
			eeprom_irq_flag, timer_run, mem_we, eeprom_addr}, 0);
		repeat (9) @(posedge ref_clk);
		nrst <= 1'b1;
		// An empty page write must find the buffer cleared by reset
		run('{1, 1, 0, 0, 1, 0, 0, 0, 10'h080, 10'h080});
		print_verdict();
	end
endmodule
`default_nettype wire
